// File: phy_access_pkg.sv
package phy_access_pkg;

  // shared types
  typedef logic [31:0] word_t;
  typedef logic [3:0] reg_index_t;
  typedef logic [4:0] target_phy_select_t;
  typedef logic [4:0] phy_reg_t;
  typedef logic [15:0] mgmt_data_t;
  typedef logic [1:0] axi_resp_t;

  // register indices on the device's own register port
  localparam reg_index_t phy_access_control_idx = 4'h6;
  localparam reg_index_t phy_access_data_idx = 4'h7;

  // phy_access_control field layout
  localparam int ctl_busy_bit = 0;
  localparam int ctl_dir_bit = 1;
  localparam int ctl_index_lsb = 6;
  localparam int ctl_phy_lsb = 11;
  localparam int data_lsb = 0;

  // reset values
  localparam target_phy_select_t target_phy_select_rst = 5'h00;
  localparam phy_reg_t phy_reg_rst = 5'h00;
  localparam mgmt_data_t data_rst = 16'h0000;
  localparam word_t word_zero = 32'h0000_0000;

  // host controller registers, byte addresses on the axi4-lite bus
  localparam logic [7:0] host_index_off = 8'h00;
  localparam logic [7:0] host_wdata_off = 8'h04;
  localparam logic [7:0] host_cmd_off = 8'h08;
  localparam logic [7:0] host_status_off = 8'h0c;
  localparam logic [7:0] host_rdata_off = 8'h10;
  localparam int cmd_write_bit = 0;
  localparam int cmd_read_bit = 1;
  localparam int status_pending_bit = 0;

  localparam axi_resp_t resp_okay = 2'h0;
  localparam axi_resp_t resp_slverr = 2'h2;

endpackage : phy_access_pkg

// File: phy_access_if.sv
`timescale 1ns/1ps
interface phy_access_if;
  import phy_access_pkg::*;

  reg_index_t index;
  logic write_en;
  logic read_en;
  word_t wdata;
  word_t rdata;
  logic rvalid;

  modport device (
    input index,
    input write_en,
    input read_en,
    input wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output index,
    output write_en,
    output read_en,
    output wdata,
    input rdata,
    input rvalid
  );

endinterface : phy_access_if

// File: phy_access_device.sv
`timescale 1ns/1ps
module phy_access_device (
  input wire logic aclk,
  input wire logic aresetn,
  phy_access_if.device link,
  output logic mgmt_req,
  output logic mgmt_write,
  output phy_access_pkg::target_phy_select_t mgmt_phy,
  output phy_access_pkg::phy_reg_t mgmt_reg,
  output phy_access_pkg::mgmt_data_t mgmt_wdata,
  input wire logic mgmt_ack,
  input wire phy_access_pkg::mgmt_data_t mgmt_rdata,
  output logic transfer_in_progress
);
  import phy_access_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } dev_state_t;

  typedef struct packed {
    dev_state_t state;
    logic busy;
    target_phy_select_t target_phy_select;
    phy_reg_t phy_register_index;
    logic transfer_direction;
    mgmt_data_t data;
    word_t rdata;
    logic rvalid;
    logic req;
    logic req_write;
    target_phy_select_t req_phy;
    phy_reg_t req_reg;
    mgmt_data_t req_wdata;
  } dev_regs_t;

  dev_regs_t r_reg;
  dev_regs_t r_next;
  word_t control_view;
  word_t data_view;

  // reserved bits are built as zero, never stored
  always_comb begin
    control_view = word_zero;
    control_view[ctl_phy_lsb +: 5] = r_reg.target_phy_select;
    control_view[ctl_index_lsb +: 5] = r_reg.phy_register_index;
    control_view[ctl_dir_bit] = r_reg.transfer_direction;
    control_view[ctl_busy_bit] = r_reg.busy;
    data_view = word_zero;
    data_view[data_lsb +: 16] = r_reg.data;
  end

  always_comb begin
    r_next = r_reg;
    r_next.rvalid = 1'b0;

    // register reads answer one cycle after the strobe
    if (link.read_en) begin
      r_next.rvalid = 1'b1;
      case (link.index)
        phy_access_control_idx: begin
          r_next.rdata = control_view;
        end
        phy_access_data_idx: begin
          r_next.rdata = data_view;
        end
        default: begin
          r_next.rdata = word_zero;
        end
      endcase
    end

    case (r_reg.state)
      st_idle: begin
        if (link.write_en && (link.index == phy_access_control_idx)) begin
          r_next.target_phy_select = link.wdata[ctl_phy_lsb +: 5];
          r_next.phy_register_index = link.wdata[ctl_index_lsb +: 5];
          r_next.transfer_direction = link.wdata[ctl_dir_bit];
          if (link.wdata[ctl_busy_bit]) begin
            r_next.state = st_busy;
            r_next.busy = 1'b1;
            r_next.req = 1'b1;
            r_next.req_write = link.wdata[ctl_dir_bit];
            r_next.req_phy = link.wdata[ctl_phy_lsb +: 5];
            r_next.req_reg = link.wdata[ctl_index_lsb +: 5];
            r_next.req_wdata = r_reg.data;
          end
        end else if (link.write_en && (link.index == phy_access_data_idx)) begin
          r_next.data = link.wdata[data_lsb +: 16];
        end
      end
      st_busy: begin
        // register writes are dropped while the transfer runs
        if (mgmt_ack) begin
          r_next.state = st_idle;
          r_next.busy = 1'b0;
          r_next.req = 1'b0;
          if (!r_reg.req_write) begin
            r_next.data = mgmt_rdata;
          end
        end
      end
      default: begin
        r_next.state = st_idle;
        r_next.busy = 1'b0;
        r_next.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg.state <= st_idle;
      r_reg.busy <= 1'b0;
      r_reg.target_phy_select <= target_phy_select_rst;
      r_reg.phy_register_index <= phy_reg_rst;
      r_reg.transfer_direction <= 1'b0;
      r_reg.data <= data_rst;
      r_reg.rdata <= word_zero;
      r_reg.rvalid <= 1'b0;
      r_reg.req <= 1'b0;
      r_reg.req_write <= 1'b0;
      r_reg.req_phy <= target_phy_select_rst;
      r_reg.req_reg <= phy_reg_rst;
      r_reg.req_wdata <= data_rst;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.rdata = r_reg.rdata;
  assign link.rvalid = r_reg.rvalid;
  assign mgmt_req = r_reg.req;
  assign mgmt_write = r_reg.req_write;
  assign mgmt_phy = r_reg.req_phy;
  assign mgmt_reg = r_reg.req_reg;
  assign mgmt_wdata = r_reg.req_wdata;
  assign transfer_in_progress = r_reg.busy;

endmodule : phy_access_device

// File: phy_access_host.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module phy_access_host #(
  parameter int axi_addr_width = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  phy_access_if.host link,
  input wire logic [axi_addr_width-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire phy_access_pkg::word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output phy_access_pkg::axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [axi_addr_width-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output phy_access_pkg::word_t rdata,
  output phy_access_pkg::axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready
);
  import phy_access_pkg::*;

  if (axi_addr_width < 8) begin : g_width_check
    $error("axi_addr_width must be at least 8");
  end

  typedef enum logic [2:0] {
    h_idle = 3'b001,
    h_write = 3'b010,
    h_read = 3'b100
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    word_t w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    axi_resp_t bresp;
    logic arready;
    logic rvalid;
    word_t rdata;
    axi_resp_t rresp;
    reg_index_t sel_index;
    word_t out_data;
    word_t in_data;
    logic write_en;
    logic read_en;
  } host_regs_t;

  host_regs_t r_reg;
  host_regs_t r_next;
  word_t mask;

  always_comb begin
    mask = word_zero;
    for (int b = 0; b < 4; b++) begin
      mask[b*8 +: 8] = {8{r_reg.w_strb[b]}};
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.write_en = 1'b0;
    r_next.read_en = 1'b0;

    // carrier sequencing
    case (r_reg.state)
      h_idle: begin
      end
      h_write: begin
        r_next.state = h_idle;
      end
      h_read: begin
        if (link.rvalid) begin
          r_next.in_data = link.rdata;
          r_next.state = h_idle;
        end
      end
      default: begin
        r_next.state = h_idle;
      end
    endcase

    // axi write: address and data held until both are present
    if (awvalid && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.aw_addr = awaddr[7:0];
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.w_data = wdata;
      r_next.w_strb = wstrb;
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = resp_okay;
      case (r_reg.aw_addr)
        host_index_off: begin
          r_next.sel_index = (r_reg.sel_index & ~mask[3:0]) | (r_reg.w_data[3:0] & mask[3:0]);
        end
        host_wdata_off: begin
          r_next.out_data = (r_reg.out_data & ~mask) | (r_reg.w_data & mask);
        end
        host_cmd_off: begin
          // commands are ignored while a carrier transfer is pending
          if (r_reg.state == h_idle && r_reg.w_strb[0]) begin
            if (r_reg.w_data[cmd_write_bit]) begin
              r_next.state = h_write;
              r_next.write_en = 1'b1;
            end else if (r_reg.w_data[cmd_read_bit]) begin
              r_next.state = h_read;
              r_next.read_en = 1'b1;
            end
          end
        end
        host_status_off, host_rdata_off: begin
        end
        default: begin
          r_next.bresp = resp_slverr;
        end
      endcase
    end
    r_next.awready = !r_next.aw_have;
    r_next.wready = !r_next.w_have;

    // axi read
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = resp_okay;
      r_next.rdata = word_zero;
      case (araddr[7:0])
        host_index_off: begin
          r_next.rdata[3:0] = r_reg.sel_index;
        end
        host_wdata_off: begin
          r_next.rdata = r_reg.out_data;
        end
        host_cmd_off: begin
        end
        host_status_off: begin
          r_next.rdata[status_pending_bit] = (r_reg.state != h_idle);
        end
        host_rdata_off: begin
          r_next.rdata = r_reg.in_data;
        end
        default: begin
          r_next.rresp = resp_slverr;
        end
      endcase
    end
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.state <= h_idle;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign awready = r_reg.awready;
  assign wready = r_reg.wready;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.arready;
  assign rvalid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign rresp = r_reg.rresp;
  assign link.index = r_reg.sel_index;
  assign link.wdata = r_reg.out_data;
  assign link.write_en = r_reg.write_en;
  assign link.read_en = r_reg.read_en;

endmodule : phy_access_host

// File: phy_access_monitor.sv
`timescale 1ns/1ps
module phy_access_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire phy_access_pkg::reg_index_t index,
  input wire logic write_en,
  input wire logic read_en,
  input wire phy_access_pkg::word_t wdata,
  input wire phy_access_pkg::word_t rdata,
  input wire logic rvalid,
  input wire logic mgmt_req,
  input wire logic mgmt_write,
  input wire logic mgmt_ack,
  input wire phy_access_pkg::target_phy_select_t mgmt_phy,
  input wire phy_access_pkg::phy_reg_t mgmt_reg,
  input wire phy_access_pkg::mgmt_data_t mgmt_wdata,
  input wire logic transfer_in_progress
);
  import phy_access_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic ctl_go;
  phy_reg_t ctl_reg;
  assign ctl_go = write_en && index == phy_access_control_idx && wdata[ctl_busy_bit];
  assign ctl_reg = wdata[ctl_index_lsb +: 5];
  sequence s_ctl;
    write_en && index == phy_access_control_idx && wdata[ctl_busy_bit];
  endsequence
  sequence s_go;
    s_ctl ##0 !transfer_in_progress;
  endsequence
  sequence s_done;
    transfer_in_progress && mgmt_ack;
  endsequence
  a_start_req: assert property (s_go |=> mgmt_req && transfer_in_progress)
    else $error("start lost");
  a_req_cause: assert property ($rose(mgmt_req) |-> $past(ctl_go))
    else $error("request without start");
  a_dir_match: assert property ($rose(mgmt_req) |-> mgmt_write == $past(wdata[ctl_dir_bit]))
    else $error("direction wrong");
  a_index_match: assert property ($rose(mgmt_req) |-> mgmt_reg == $past(ctl_reg))
    else $error("register index wrong");
  a_target_stable: assert property (mgmt_req && !mgmt_ack |=>
    $stable(mgmt_phy) && $stable(mgmt_reg) && $stable(mgmt_wdata))
    else $error("target moved");
  a_busy_hold: assert property (transfer_in_progress && !mgmt_ack |=> transfer_in_progress)
    else $error("busy dropped");
  a_busy_clear: assert property (s_done |=> !transfer_in_progress && !mgmt_req)
    else $error("busy stuck");
  a_fields_stable: assert property (mgmt_req && !mgmt_ack |=> mgmt_req && $stable(mgmt_write))
    else $error("fields moved");
  a_read_answer: assert property (read_en |=> rvalid)
    else $error("no read answer");
  a_answer_cause: assert property (rvalid |-> $past(read_en))
    else $error("stray answer");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper bits set");
endmodule : phy_access_monitor

// File: phy_register_access_port_bench.sv
`timescale 1ns/1ps
module phy_register_access_port_bench;
  import phy_access_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] wstrb = 4'hf;
  word_t wdata = 32'h0, rdata, rd_q;
  logic awready, wready, bvalid, arready, rvalid, mgmt_req, mgmt_write;
  logic transfer_in_progress;
  axi_resp_t bresp, rresp, resp_q;
  target_phy_select_t mgmt_phy;
  phy_reg_t mgmt_reg;
  mgmt_data_t mgmt_wdata, mem [1024];
  logic mgmt_ack = 1'h0;
  mgmt_data_t mgmt_rdata = 16'h0;
  int n_errors = 0, total_checks = 0, lat = 0, cnt = 0, n_xfer = 0, k;
  always #10 aclk = ~aclk;
  phy_access_if lnk ();
  phy_access_host u_phy_access_host (.aclk, .aresetn, .link(lnk), .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  phy_access_device u_phy_access_device (.aclk, .aresetn, .link(lnk), .mgmt_req,
    .mgmt_write, .mgmt_phy, .mgmt_reg, .mgmt_wdata, .mgmt_ack, .mgmt_rdata,
    .transfer_in_progress);
  phy_access_monitor u_phy_access_monitor (.aclk, .aresetn, .index(lnk.index),
    .write_en(lnk.write_en), .read_en(lnk.read_en), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .rvalid(lnk.rvalid), .mgmt_req, .mgmt_write, .mgmt_ack, .mgmt_phy, .mgmt_reg,
    .mgmt_wdata, .transfer_in_progress);
  // phy side: answers lat+1 cycles after the request, scrambles read data outside the ack cycle
  always @(posedge aclk) begin
    mgmt_ack <= 1'h0;
    mgmt_rdata <= ~mgmt_rdata;
    if (mgmt_req && !mgmt_ack) begin
      cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt <= 0;
        mgmt_ack <= 1'h1;
        n_xfer <= n_xfer + 1;
        if (mgmt_write) mem[{mgmt_phy, mgmt_reg}] <= mgmt_wdata;
        else mgmt_rdata <= mem[{mgmt_phy, mgmt_reg}];
      end
    end
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic bad(input string s);
    n_errors++;
    $display("ERROR %0t %s", $time, s);
  endtask : bad
  task automatic chk_word(input word_t g, input word_t e);
    total_checks++;
    if (g !== e) bad($sformatf("word %h expected %h", g, e));
  endtask : chk_word
  task automatic chk_resp(input axi_resp_t g, input axi_resp_t e);
    total_checks++;
    if (g !== e) bad($sformatf("resp %h expected %h", g, e));
  endtask : chk_resp
  task automatic hang;
    bad("timeout");
    stop_test();
  endtask : hang
  task automatic axi_wr(input logic [7:0] a, input word_t d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        resp_q = bresp;
        bready <= 1'h0;
        break;
      end
    end
    if (i == 64) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'h0;
        break;
      end
    end
    if (i == 64) hang();
  endtask : axi_rd
  task automatic dev_wr(input reg_index_t x, input word_t w);
    axi_wr(host_index_off, {28'h0, x});
    axi_wr(host_wdata_off, w);
    axi_wr(host_cmd_off, 32'h1);
  endtask : dev_wr
  task automatic dev_rd(input reg_index_t x);
    int i;
    axi_wr(host_index_off, {28'h0, x});
    axi_wr(host_cmd_off, 32'h2);
    for (i = 0; i < 20; i++) begin
      axi_rd(host_status_off);
      if (rd_q[0] === 1'h0) break;
    end
    if (i == 20) hang();
    axi_rd(host_rdata_off);
  endtask : dev_rd
  task automatic wait_idle;
    int i;
    for (i = 0; i < 50; i++) begin
      dev_rd(phy_access_control_idx);
      if (rd_q[0] === 1'h0) break;
    end
    if (i == 50) hang();
  endtask : wait_idle
  function automatic word_t ctl(input target_phy_select_t p, input phy_reg_t g, input logic w,
    input logic go);
    return {16'h0000, p, g, 4'h0, w, go};
  endfunction : ctl
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 16'hc000 + 16'(i);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    dev_rd(phy_access_control_idx);
    chk_word(rd_q, word_zero);
    dev_rd(phy_access_data_idx);
    chk_word(rd_q, word_zero);
    axi_rd(8'h40);
    chk_resp(resp_q, resp_slverr);
    axi_wr(8'h40, word_zero);
    chk_resp(resp_q, resp_slverr);
    axi_wr(host_wdata_off, 32'h1111_1111);
    chk_resp(resp_q, resp_okay);
    wstrb <= 4'h1;
    axi_wr(host_wdata_off, 32'h2222_2222);
    wstrb <= 4'hf;
    axi_rd(host_wdata_off);
    chk_word(rd_q, 32'h1111_1122);
    dev_rd(4'h3);
    chk_word(rd_q, word_zero);
    lat = 40;
    dev_wr(phy_access_data_idx, 32'hffff_1234);
    dev_rd(phy_access_data_idx);
    chk_word(rd_q, 32'h0000_1234);
    dev_wr(phy_access_control_idx, ctl(5'h03, 5'h09, 1'h1, 1'h1) | 32'hffff_003c);
    dev_rd(phy_access_control_idx);
    chk_word(rd_q, ctl(5'h03, 5'h09, 1'h1, 1'h1));
    dev_wr(phy_access_control_idx, ctl(5'h07, 5'h01, 1'h0, 1'h1));
    dev_wr(phy_access_data_idx, 32'h0000_beef);
    wait_idle();
    chk_word({16'h0000, mem[{5'h03, 5'h09}]}, 32'h0000_1234);
    chk_word(rd_q, ctl(5'h03, 5'h09, 1'h1, 1'h0));
    lat = 0;
    dev_wr(phy_access_control_idx, ctl(5'h1f, 5'h1e, 1'h0, 1'h1));
    wait_idle();
    dev_rd(phy_access_data_idx);
    chk_word(rd_q, 32'h0000_c3fe);
    k = n_xfer;
    dev_wr(phy_access_control_idx, ctl(5'h05, 5'h02, 1'h1, 1'h0));
    dev_rd(phy_access_control_idx);
    chk_word(rd_q, ctl(5'h05, 5'h02, 1'h1, 1'h0));
    chk_word(32'(n_xfer), 32'(k));
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    dev_rd(phy_access_control_idx);
    chk_word(rd_q, word_zero);
    stop_test();
  end
endmodule : phy_register_access_port_bench
